// ### frsp_core.sv
/*
 Core-side requester: turns user write commands into link writes and
 raises busy while the sequencer stalls; cmdReady drops only while a write is held.
 Assumes the device end drives wrReady and stall combinationally.
*/
`timescale 1ns/10ps
`default_nettype none
`include "frsp_defines.svh"

module frsp_core (
   input  wire logic                 sys_clk,
   input  wire logic                 sys_rst,
   frsp_if.core                      link,
   input  wire logic                 cmdValid,
   input  wire frsp_pkg::frsp_tgt_e  cmdTarget,
   input  wire frsp_pkg::frsp_addr_t cmdAddr,
   input  wire frsp_pkg::frsp_word_t cmdData,
   output logic                      cmdReady,
   output logic                      busy
);

   // -----------------------------------------------------------------
   // Request holding
   // -----------------------------------------------------------------
   logic                 pend, next_pend;
   frsp_pkg::frsp_tgt_e  tgt, next_tgt;
   frsp_pkg::frsp_addr_t addr, next_addr;
   frsp_pkg::frsp_word_t data, next_data;

   // One write held at a time keeps key writes consecutive
   assign cmdReady     = !pend;
   assign link.wrValid = pend;
   assign link.wrTarget = tgt;
   assign link.wrAddr  = addr;
   assign link.wrData  = data;
   assign busy         = pend || link.stall;

   // Capture a command, release it when the device takes it
   always_comb begin
      next_pend = pend;
      next_tgt  = tgt;
      next_addr = addr;
      next_data = data;
      if (pend && link.wrReady) begin
         next_pend = 1'b0;
      end
      if (cmdValid && !pend) begin
         next_pend = 1'b1;
         next_tgt  = cmdTarget;
         next_addr = cmdAddr;
         next_data = cmdData;
      end
   end

   // Register the held request
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         pend <= 1'b0;
         tgt  <= frsp_pkg::FRSP_TGT_LATCH;
         addr <= '0;
         data <= '0;
      end else begin
         pend <= next_pend;
         tgt  <= next_tgt;
         addr <= next_addr;
         data <= next_data;
      end
   end

endmodule

`default_nettype wire

// ### frsp_defines.svh
/*
 Constants for the flash row self-programming sequencer: geometry, key
 values, control bit positions and operation timing.
 Assumes inclusion by bare name from the package and both design ends.
*/
// Operation
// - Array organised as 64-word, 192-byte rows
// - Erase eight-row blocks; program row or word
// - Erase and row blocks aligned from memory start
// - Table writes land in latches, not array
// - Any latch count accepted; 64 fill row
// - Software fills unused latches with all ones
// - Latches load in any order; last wins
// - Software avoids reprogramming without an erase
// - Latch write completes in two cycles
// - Each row needs its own programming cycle
// - Pointer, then latch loads, then control start
// - Control selects erase, memory type, start; code decodes only op bits 3:0 and start bit 15, no memory type
// - Write-only key needs 55h then AAh
// - Processor stalls while operation in progress
// - Start bit 15 self-clears when done
`ifndef FRSP_DEFINES_SVH
`define FRSP_DEFINES_SVH

`define FRSP_ROW_WORDS      64
`define FRSP_ROW_BYTES      192
`define FRSP_ERASE_ROWS     8
`define FRSP_ERASE_WORDS    512
`define FRSP_ERASE_BYTES    1536
`define FRSP_WORD_W         24
`define FRSP_ADDR_W         24
`define FRSP_IDX_W          6
`define FRSP_KEY_FIRST      8'h55
`define FRSP_KEY_SECOND     8'hAA
`define FRSP_ERASED_WORD    24'hFF_FFFF
`define FRSP_CTL_START_BIT  15
`define FRSP_CTL_OP_LSB     0
`define FRSP_CTL_OP_W       4
`define FRSP_CTL_RESET      16'h0000
`define FRSP_LATCH_CYCLES   2
`define FRSP_OP_TIME_NS     2000
`define FRSP_CLK_NS         10
`define FRSP_OP_CYCLES      ((`FRSP_OP_TIME_NS + `FRSP_CLK_NS - 1) / `FRSP_CLK_NS)

`endif

// ### frsp_device.sv
/*
 Flash row self-programming sequencer: holding latches, unlock key,
 control register with self-clearing start bit and a flash array model.
 Assumes the core end obeys wrReady and issues one write at a time.
 Array words above ARRAY_WORDS alias, since only the low address bits
 select a word; latches and array have no reset and start unknown.
 Operation time is a fixed count, not a model of real cell timing.
*/
`timescale 1ns/10ps
`default_nettype none
`include "frsp_defines.svh"

module frsp_device #(
   parameter int ARRAY_WORDS = 4096
) (
   input  wire logic          sys_clk,
   input  wire logic          sys_rst,
   frsp_if.device             link,
   input  wire logic [11:0]   rdAddr,
   output logic [23:0]        rdData,
   output logic [15:0]        ctlState
);

   // -----------------------------------------------------------------
   // State
   // -----------------------------------------------------------------
   typedef enum logic [1:0] {
      FRSP_ST_IDLE  = 2'b00,
      FRSP_ST_LATCH = 2'b01,
      FRSP_ST_BUSY  = 2'b10
   } frsp_state_e;

   localparam logic [15:0] OP_CYC = 16'(`FRSP_OP_CYCLES);

   // Operation bookkeeping
   frsp_state_e             state, next_state;
   logic [1:0]              keyStage, next_keyStage;
   logic [15:0]             ctl, next_ctl;
   logic [15:0]             cnt, next_cnt;
   logic [`FRSP_ADDR_W-1:0] opAddr, next_opAddr;
   logic                    done, next_done;
   logic                    refused, next_refused;

   // Latches and array model: no reset, the latches power up unknown
   logic [`FRSP_WORD_W-1:0] latch [0:`FRSP_ROW_WORDS-1];
   logic [`FRSP_WORD_W-1:0] flashMem [0:ARRAY_WORDS-1];

   // Decoded strobes and block bounds
   logic        keyWr, ctlWr, latchWr, startReq;
   logic        opFinal;
   logic [11:0] rowBase, eraseBase;
   logic [12:0] rowEnd, eraseEnd;

   // -----------------------------------------------------------------
   // Decode
   // -----------------------------------------------------------------
   // wrReady low holds the core through latch settle and operation; stall marks the operation only
   assign link.wrReady  = (state == FRSP_ST_IDLE);
   assign link.stall    = (state == FRSP_ST_BUSY);
   assign link.opDone   = done;
   assign link.opRefused = refused;
   assign ctlState      = ctl;

   // Writes only count while idle, so none can slip in mid-operation
   assign keyWr   = link.wrValid && link.wrReady && (link.wrTarget == frsp_pkg::FRSP_TGT_KEY);
   assign ctlWr   = link.wrValid && link.wrReady && (link.wrTarget == frsp_pkg::FRSP_TGT_CTL);
   assign latchWr = link.wrValid && link.wrReady && (link.wrTarget == frsp_pkg::FRSP_TGT_LATCH);
   assign startReq = ctlWr && link.wrData[`FRSP_CTL_START_BIT];

   // Row base on 192-byte boundaries, erase base on 1536-byte ones
   assign rowBase   = 12'(opAddr / `FRSP_ROW_WORDS * `FRSP_ROW_WORDS);
   assign eraseBase = 12'(opAddr / `FRSP_ERASE_WORDS * `FRSP_ERASE_WORDS);

   // Ends in 13 bits: the top block's end would wrap to zero in 12
   assign rowEnd    = 13'(rowBase) + 13'(`FRSP_ROW_WORDS);
   assign eraseEnd  = 13'(eraseBase) + 13'(`FRSP_ERASE_WORDS);

   // Last busy cycle; the array is written only here
   assign opFinal   = (state == FRSP_ST_BUSY) && (cnt == 16'd1);

   // -----------------------------------------------------------------
   // Next state
   // -----------------------------------------------------------------
   // Key, control and sequence stepping
   always_comb begin
      next_state    = state;
      next_keyStage = keyStage;
      next_ctl      = ctl;
      next_cnt      = cnt;
      next_opAddr   = opAddr;
      next_done     = 1'b0;
      next_refused  = 1'b0;
      case (state)
         FRSP_ST_IDLE: begin
            if (keyWr) begin
               // Second key only counts right after the first
               if (link.wrData[7:0] == `FRSP_KEY_FIRST) begin
                  next_keyStage = 2'd1;
               end else if (keyStage == 2'd1 && link.wrData[7:0] == `FRSP_KEY_SECOND) begin
                  next_keyStage = 2'd2;
               end else begin
                  next_keyStage = 2'd0;
               end
            end else if (ctlWr) begin
               // A refused start still stores the low control bits
               next_keyStage = 2'd0;
               next_ctl = {1'b0, link.wrData[14:0]};
               if (startReq && keyStage == 2'd2) begin
                  next_ctl[`FRSP_CTL_START_BIT] = 1'b1;
                  next_state = FRSP_ST_BUSY;
                  next_cnt   = OP_CYC;
               end else if (startReq) begin
                  next_refused = 1'b1;
               end
            end else if (latchWr) begin
               next_keyStage = 2'd0;
               next_opAddr   = link.wrAddr;
               next_state    = FRSP_ST_LATCH;
            end
         end
         FRSP_ST_LATCH: begin
            // Second cycle of a latch write; wrReady low holds the core
            next_state = FRSP_ST_IDLE;
         end
         FRSP_ST_BUSY: begin
            // No write is taken here, so the key cannot be armed early
            if (cnt == 16'd1) begin
               next_ctl[`FRSP_CTL_START_BIT] = 1'b0;
               next_state = FRSP_ST_IDLE;
               next_done  = 1'b1;
            end else begin
               next_cnt = cnt - 16'd1;
            end
         end
         default: begin
            // Unused code falls back to idle
            next_state = FRSP_ST_IDLE;
         end
      endcase
   end

   // Register control state
   // Pulses last one cycle since their next values default low
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         state    <= FRSP_ST_IDLE;
         keyStage <= 2'd0;
         ctl      <= `FRSP_CTL_RESET;
         cnt      <= 16'd0;
         opAddr   <= '0;
         done     <= 1'b0;
         refused  <= 1'b0;
      end else begin
         state    <= next_state;
         keyStage <= next_keyStage;
         ctl      <= next_ctl;
         cnt      <= next_cnt;
         opAddr   <= next_opAddr;
         done     <= next_done;
         refused  <= next_refused;
      end
   end

   // -----------------------------------------------------------------
   // Latches and array
   // -----------------------------------------------------------------
   // Later writes overwrite; order free
   always_ff @(posedge sys_clk) begin
      if (latchWr) begin
         latch[link.wrAddr[`FRSP_IDX_W-1:0]] <= link.wrData;
      end
   end

   // Array changes only on the final cycle of a started operation;
   // one row per program operation, so each row needs its own start
   // Word program takes the latch at the word's own index
   generate
      for (genvar g = 0; g < ARRAY_WORDS; g++) begin : gWord
         localparam logic [11:0] ADDR = 12'(g);
         always_ff @(posedge sys_clk) begin
            if (opFinal) begin
               if (ctl[3:0] == frsp_pkg::FRSP_OP_ERASE &&
                   ADDR >= eraseBase && 13'(ADDR) < eraseEnd) begin
                  flashMem[g] <= `FRSP_ERASED_WORD;
               end else if (ctl[3:0] == frsp_pkg::FRSP_OP_ROW &&
                   ADDR >= rowBase && 13'(ADDR) < rowEnd) begin
                  flashMem[g] <= latch[ADDR[`FRSP_IDX_W-1:0]];
               end else if (ctl[3:0] == frsp_pkg::FRSP_OP_WORD &&
                   ADDR == opAddr[11:0]) begin
                  flashMem[g] <= latch[ADDR[`FRSP_IDX_W-1:0]];
               end
            end
         end
      end
   endgenerate

   // Registered read port for checking array content;
   // words never written read back unknown
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         rdData <= '0;
      end else begin
         rdData <= flashMem[rdAddr];
      end
   end

endmodule

`default_nettype wire

// ### frsp_if.sv
/*
 Link between the core-side requester and the flash sequencer.
 Assumes one clock shared by both ends; no clocking block.
*/
`timescale 1ns/10ps
`default_nettype none

interface frsp_if;
   logic                 wrValid;   // Core write request
   frsp_pkg::frsp_tgt_e  wrTarget;  // Latch, key or control
   frsp_pkg::frsp_addr_t wrAddr;    // Table pointer for latch writes
   frsp_pkg::frsp_word_t wrData;    // Latch word, key or control value
   logic                 wrReady;   // Sequencer takes the write
   logic                 stall;     // Operation in progress
   logic                 opDone;    // One-cycle pulse at completion
   logic                 opRefused; // One-cycle pulse for bad start

   modport device (
      input  wrValid, wrTarget, wrAddr, wrData,
      output wrReady, stall, opDone, opRefused
   );
   modport core (
      output wrValid, wrTarget, wrAddr, wrData,
      input  wrReady, stall, opDone, opRefused
   );
endinterface

`default_nettype wire

// ### frsp_pkg.sv
/*
 Types shared by both ends of the flash row self-programming link.
 Assumes the defines header is available on the include path.
*/
`include "frsp_defines.svh"

package frsp_pkg;

   // Operation codes carried in the low control bits
   typedef enum logic [3:0] {
      FRSP_OP_WORD  = 4'h3,
      FRSP_OP_ROW   = 4'h1,
      FRSP_OP_ERASE = 4'h2
   } frsp_op_e;

   // Bus write target selector from the core
   typedef enum logic [1:0] {
      FRSP_TGT_LATCH = 2'h0,
      FRSP_TGT_KEY   = 2'h1,
      FRSP_TGT_CTL   = 2'h2
   } frsp_tgt_e;

   typedef logic [`FRSP_WORD_W-1:0] frsp_word_t;
   typedef logic [`FRSP_ADDR_W-1:0] frsp_addr_t;

endpackage

// ### frsp_properties.sv
/*
 Checker for the link between core end and flash sequencer.
 Assumes the testbench wires the interface signals in by name.
*/
`timescale 1ns/10ps
`default_nettype none
`include "frsp_defines.svh"
// ----------------------------------------
// Link checker
// ----------------------------------------
module frsp_properties (
   input wire logic               sys_clk,
   input wire logic               sys_rst,
   input wire logic               wrValid,
   input var frsp_pkg::frsp_tgt_e wrTarget,
   input wire logic [23:0]        wrData,
   input wire logic               wrReady,
   input wire logic               stall,
   input wire logic               opDone,
   input wire logic               opRefused
);
   localparam int OPC = `FRSP_OP_CYCLES;
   logic       taken;
   logic       isKey;
   logic       isStart;
   logic       firstKey;
   logic       keyOk;
   logic [8:0] runLen;

   // Write taken this edge; start needs bit 15 of a control write
   assign taken   = wrValid && wrReady;
   assign isKey   = wrTarget == frsp_pkg::FRSP_TGT_KEY;
   assign isStart = taken && wrTarget == frsp_pkg::FRSP_TGT_CTL && wrData[15];

   // Key tracker: any other write between the two values spoils the pair
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         firstKey <= 1'b0;
         keyOk    <= 1'b0;
         runLen   <= 9'd0;
      end else begin
         runLen <= stall ? runLen + 9'd1 : 9'd0;
         if (taken) begin
            firstKey <= isKey && wrData[7:0] == `FRSP_KEY_FIRST;
            keyOk    <= isKey && wrData[7:0] == `FRSP_KEY_SECOND && firstKey;
         end
      end
   end

   default clocking dcb @(posedge sys_clk);
   endclocking
   default disable iff (sys_rst);

   start_no_key_a: assert property (isStart && !keyOk |=> opRefused && !stall)
      else $error("start without key was not refused");
   start_key_a: assert property (isStart && keyOk |=> stall && !opRefused)
      else $error("keyed start did not stall");
   key_silent_a: assert property (taken && isKey |=> wrReady && !stall && !opRefused)
      else $error("key write gave an answer");
   latch_two_a: assert property (taken && wrTarget == frsp_pkg::FRSP_TGT_LATCH |=> !wrReady ##1 wrReady)
      else $error("latch write not two cycles");
   stall_len_a: assert property (opDone |-> runLen == OPC)
      else $error("operation length wrong");
   stall_bound_a: assert property (stall |-> runLen < OPC && !wrReady)
      else $error("stall too long or write taken");
   done_end_a: assert property ($fell(stall) |-> opDone ##1 !opDone)
      else $error("completion pulse wrong");
   refuse_pulse_a: assert property (opRefused |=> !opRefused && !stall)
      else $error("refusal pulse wrong");

   cover property (isStart && keyOk);
   cover property (opRefused);
   cover property (opDone);
endmodule
`default_nettype wire

// ### testbench.sv
/*
 Self-checking bench for core end and sequencer joined by the link.
 Assumes package, header, interface and both design ends compile first.
*/
`timescale 1ns/10ps
`default_nettype none
`include "frsp_defines.svh"
module testbench;
   localparam int OPC = `FRSP_OP_CYCLES;
   localparam logic [23:0] FF = `FRSP_ERASED_WORD;
   logic                 sys_clk;
   logic                 sys_rst;
   logic                 cmdValid;
   logic                 cmdReady;
   logic                 busy;
   frsp_pkg::frsp_tgt_e  cmdTarget;
   frsp_pkg::frsp_addr_t cmdAddr;
   frsp_pkg::frsp_word_t cmdData;
   logic [11:0]          rdAddr;
   logic [23:0]          rdData;
   logic [15:0]          ctlState;
   int                   err_count;
   int                   checks_done;
   // Latch address, value written, array word expected; last row sits off the row base
   logic [23:0] rowTab [4][3] = '{'{24'h41, 24'h11_1111, 24'h22_2222}, '{24'h40, 24'h44_4444, 24'h44_4444},
      '{24'h41, 24'h22_2222, 24'h22_2222}, '{24'h7F, 24'h33_3333, 24'h33_3333}};

   frsp_if link ();
   frsp_core i_frsp_core (.sys_clk(sys_clk), .sys_rst(sys_rst), .link(link), .cmdValid(cmdValid),
      .cmdTarget(cmdTarget), .cmdAddr(cmdAddr), .cmdData(cmdData), .cmdReady(cmdReady), .busy(busy));
   frsp_device i_frsp_device (.sys_clk(sys_clk), .sys_rst(sys_rst), .link(link), .rdAddr(rdAddr),
      .rdData(rdData), .ctlState(ctlState));
   frsp_properties i_frsp_properties (.sys_clk(sys_clk), .sys_rst(sys_rst), .wrValid(link.wrValid),
      .wrTarget(link.wrTarget), .wrData(link.wrData), .wrReady(link.wrReady), .stall(link.stall),
      .opDone(link.opDone), .opRefused(link.opRefused));

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask

   task automatic report_and_stop;
      if (err_count == 0 && checks_done > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   // One user command; waits bounded for the core to be free
   task automatic send(input frsp_pkg::frsp_tgt_e t, input logic [23:0] a, input logic [23:0] d);
      int n;
      n = 0;
      while (cmdReady !== 1'b1) begin
         @(negedge sys_clk);
         n++;
         if (n > 500) begin
            err_count++;
            report_and_stop();
         end
      end
      cmdValid = 1'b1;
      cmdTarget = t;
      cmdAddr = a;
      cmdData = d;
      @(negedge sys_clk);
      cmdValid = 1'b0;
   endtask

   // Start an operation, optionally keyed, and judge its outcome
   task automatic op(input logic [3:0] code, input bit ok);
      int st;
      bit done;
      bit refused;
      st = 0;
      done = 0;
      refused = 0;
      if (ok) send(frsp_pkg::FRSP_TGT_KEY, 0, `FRSP_KEY_FIRST);
      if (ok) send(frsp_pkg::FRSP_TGT_KEY, 0, `FRSP_KEY_SECOND);
      send(frsp_pkg::FRSP_TGT_CTL, 0, {8'h00, 1'b1, 11'h000, code});
      for (int n = 0; n < 400 && !done && !refused; n++) begin
         @(negedge sys_clk);
         if (link.stall === 1'b1) begin
            st++;
            chk({ctlState[15], busy}, 2'b11);
         end
         done = done | (link.opDone === 1'b1);
         refused = refused | (link.opRefused === 1'b1);
      end
      chk(24'({done, refused}), 24'({ok, !ok}));
      chk(24'(st), 24'(ok ? OPC : 0));
      chk(24'(ctlState), {12'h000, 8'h00, code});
      if (!done && !refused) report_and_stop();
   endtask

   task automatic rd(input logic [11:0] a, input logic [23:0] exp);
      rdAddr = a;
      @(negedge sys_clk);
      chk(rdData, exp);
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      sys_rst = 1'b1;
      cmdValid = 1'b0;
      cmdTarget = frsp_pkg::FRSP_TGT_LATCH;
      cmdAddr = '0;
      cmdData = '0;
      rdAddr = '0;
      err_count = 0;
      checks_done = 0;
      repeat (3) @(negedge sys_clk);
      chk(24'({ctlState, link.stall, link.wrReady, busy}), 24'h00_0002);
      sys_rst = 1'b0;
      for (int i = 64; i < 128; i++) send(frsp_pkg::FRSP_TGT_LATCH, i, FF);
      for (int i = 0; i < 4; i++) send(frsp_pkg::FRSP_TGT_LATCH, rowTab[i][0], rowTab[i][1]);
      op(frsp_pkg::FRSP_OP_ROW, 1);
      for (int i = 0; i < 4; i++) rd(rowTab[i][0][11:0], rowTab[i][2]);
      rd(12'h042, FF);
      // Latch writes alone must leave the array alone
      send(frsp_pkg::FRSP_TGT_LATCH, 24'h41, 24'h12_3456);
      rd(12'h041, 24'h22_2222);
      send(frsp_pkg::FRSP_TGT_LATCH, 24'h45, 24'h00_0000);
      op(frsp_pkg::FRSP_OP_ERASE, 1);
      rd(12'h041, FF);
      rd(12'h07F, FF);
      send(frsp_pkg::FRSP_TGT_LATCH, 24'h47, 24'h5A_5A5A);
      op(frsp_pkg::FRSP_OP_WORD, 1);
      rd(12'h047, 24'h5A_5A5A);
      rd(12'h048, FF);
      // Refusals: no key, then a key pair split by a latch write
      op(frsp_pkg::FRSP_OP_ROW, 0);
      send(frsp_pkg::FRSP_TGT_KEY, 0, `FRSP_KEY_FIRST);
      send(frsp_pkg::FRSP_TGT_LATCH, 24'h47, 24'h00_0000);
      send(frsp_pkg::FRSP_TGT_KEY, 0, `FRSP_KEY_SECOND);
      op(frsp_pkg::FRSP_OP_WORD, 0);
      rd(12'h047, 24'h5A_5A5A);
      report_and_stop();
   end
endmodule
`default_nettype wire
